// ### common/sfcs_cfg.svh
// Opcodes, status bits, layout limits and timing of the flash sequencer
`ifndef SFCS_CFG_SVH
`define SFCS_CFG_SVH
`define SFCS_OP_RDID 8'h9f
`define SFCS_OP_RDSR 8'h05
`define SFCS_OP_WREN 8'h06
`define SFCS_OP_CE 8'hc7
`define SFCS_OP_READ 8'h03
`define SFCS_OP_PP 8'h02
`define SFCS_OP_SE 8'h20
`define SFCS_ST_BUSY 0
`define SFCS_ST_WEL 1
`define SFCS_RDID_LEN 10'h004
`define SFCS_RDSR_LEN 10'h002
`define SFCS_ADDR_LEN 10'h004
`define SFCS_PP_MAX 9'h0ff
`define SFCS_BLK_LSB 12
`define SFCS_SAFE_MIN_BLK 15'h0002
`define SFCS_MAX_FILES 8'h80
`define SFCS_MAX_FILE 25'h1000000
`define SFCS_AP_PAGE 20'h44020
`define SFCS_CS_RST 1'b1
`define SFCS_CLK_NS 20
`define SFCS_CS_HIGH_NS 100
`define SFCS_GAP_CYC ((`SFCS_CS_HIGH_NS + `SFCS_CLK_NS - 1) / `SFCS_CLK_NS)
`endif

// ### common/sfcs_pkg.sv
// Types of the flash sequencer
package sfcs_pkg;
  typedef enum logic [2:0] {
    sfcs_cmd_rdid = 3'b000,
    sfcs_cmd_rdsr = 3'b001,
    sfcs_cmd_wren = 3'b010,
    sfcs_cmd_chip_erase = 3'b011,
    sfcs_cmd_read = 3'b100,
    sfcs_cmd_program = 3'b101,
    sfcs_cmd_sect_erase = 3'b110
  } sfcs_cmd_type;
  typedef enum logic [1:0] {
    sfcs_ph_idle = 2'b00,
    sfcs_ph_issue = 2'b01,
    sfcs_ph_wait = 2'b10,
    sfcs_ph_gap = 2'b11
  } sfcs_phase_type;
  typedef enum logic [1:0] {
    sfcs_st_wren = 2'b00,
    sfcs_st_wel = 2'b01,
    sfcs_st_main = 2'b10,
    sfcs_st_poll = 2'b11
  } sfcs_step_type;
  typedef struct packed {
    sfcs_phase_type phase;
    sfcs_step_type step;
    sfcs_cmd_type op;
    logic [23:0] addr;
    logic [8:0] len;
    logic [9:0] idx;
    logic [9:0] nbytes;
    logic [2:0] gap;
    logic req;
    logic [7:0] txb;
    logic ack_s1;
    logic ack_s2;
    logic cs_n;
    logic [7:0] stat;
    logic [23:0] id;
    logic [7:0] rd;
    logic rd_valid;
    logic done;
    logic err;
    logic [7:0] files;
    logic [12:0] next_blk;
    logic [12:0] fs_blks;
    logic al_done;
    logic al_ok;
    logic [23:0] al_addr;
    logic ap_hit;
  } sfcs_seq_type;
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic seen;
    logic miso_s1;
    logic miso_s2;
    logic active;
    logic [4:0] cnt;
    logic [7:0] sh;
    logic [7:0] rx;
    logic ack;
    logic sck;
    logic mosi;
  } sfcs_eng_type;
endpackage : sfcs_pkg

// ### common/sfcs_link_if.sv
// Byte handshake between the sequencer and the link-clock bit engine
`timescale 1ns/100ps
interface sfcs_link_if;
  logic req_tgl;
  logic [7:0] tx_byte;
  logic ack_tgl;
  logic [7:0] rx_byte;
  modport seq (output req_tgl, output tx_byte, input ack_tgl,
    input rx_byte);
  modport eng (input req_tgl, input tx_byte, output ack_tgl,
    output rx_byte);
endinterface : sfcs_link_if

// ### hdl/sfcs_spi_engine.sv
// Bit engine of the flash port, clocked by the link clock
`timescale 1ns/100ps
module sfcs_spi_engine (
  input logic link_clk,
  input logic sys_rst,
  sfcs_link_if.eng lnk,
  input logic flash_spi_miso,
  output logic flash_spi_sck,
  output logic flash_spi_mosi
);
  logic rst_meta_q;
  logic rst_q;
  sfcs_pkg::sfcs_eng_type q;
  sfcs_pkg::sfcs_eng_type d;

  // Reset carried into the link domain
  always_ff @(posedge link_clk) begin
    rst_meta_q <= sys_rst;
    rst_q <= rst_meta_q;
  end

  // Four link cycles a bit, so the twice-synced data line still lands
  always_comb begin
    d = q;
    d.req_s1 = lnk.req_tgl;
    d.req_s2 = q.req_s1;
    d.miso_s1 = flash_spi_miso;
    d.miso_s2 = q.miso_s1;
    if (!q.active) begin
      if (q.req_s2 != q.seen) begin
        d.seen = q.req_s2;
        d.sh = lnk.tx_byte;
        d.cnt = 5'h00;
        d.active = 1'b1;
      end
    end else begin
      d.cnt = q.cnt + 5'h01;
      case (q.cnt[1:0])
        2'b00: d.mosi = q.sh[7];
        2'b01: d.sck = 1'b1;
        2'b11: begin
          d.sck = 1'b0;
          d.sh = {q.sh[6:0], q.miso_s2};
          if (q.cnt[4:2] == 3'h7) begin
            d.active = 1'b0;
            d.rx = {q.sh[6:0], q.miso_s2};
            d.ack = q.seen;
          end
        end
        default: d.sck = q.sck;
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst_q) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.ack_tgl = q.ack;
  assign lnk.rx_byte = q.rx;
  assign flash_spi_sck = q.sck;
  assign flash_spi_mosi = q.mosi;
endmodule : sfcs_spi_engine

// ### hdl/sfcs_top.sv
// Serial flash command sequencer with file block allocator
`timescale 1ns/100ps
`include "sfcs_cfg.svh"
module sfcs_top (
  input logic sys_clk,
  input logic sys_rst,
  input logic link_clk,
  input logic cmd_valid,
  output logic cmd_ready,
  input sfcs_pkg::sfcs_cmd_type cmd_op,
  input logic [23:0] cmd_addr,
  input logic [8:0] cmd_len,
  input logic [7:0] wr_data,
  input logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic cmd_done,
  output logic cmd_err,
  output logic [23:0] flash_id,
  output logic [7:0] flash_status,
  input logic fmt_valid,
  input logic [12:0] fmt_blocks,
  input logic alloc_valid,
  input logic [24:0] alloc_bytes,
  input logic alloc_safe,
  output logic alloc_done,
  output logic alloc_ok,
  output logic [23:0] alloc_addr,
  input logic [31:0] ap_addr,
  output logic ap_hit,
  output logic flash_spi_cs_n,
  output logic flash_spi_sck,
  output logic flash_spi_mosi,
  input logic flash_spi_miso
);
  sfcs_pkg::sfcs_seq_type q;
  sfcs_pkg::sfcs_seq_type d;
  logic [7:0] tx_now;
  logic need_wr;
  logic [13:0] al_blk;
  logic [13:0] al_base;
  logic [14:0] al_dbl;
  logic [14:0] al_need;
  logic al_fit;
  logic al_pass;

  sfcs_link_if lnk ();

  function automatic logic [7:0] opcode(sfcs_pkg::sfcs_cmd_type c);
    case (c)
      sfcs_pkg::sfcs_cmd_rdid: opcode = `SFCS_OP_RDID;
      sfcs_pkg::sfcs_cmd_rdsr: opcode = `SFCS_OP_RDSR;
      sfcs_pkg::sfcs_cmd_wren: opcode = `SFCS_OP_WREN;
      sfcs_pkg::sfcs_cmd_chip_erase: opcode = `SFCS_OP_CE;
      sfcs_pkg::sfcs_cmd_program: opcode = `SFCS_OP_PP;
      sfcs_pkg::sfcs_cmd_sect_erase: opcode = `SFCS_OP_SE;
      default: opcode = `SFCS_OP_READ;
    endcase
  endfunction : opcode

  function automatic logic has_addr(sfcs_pkg::sfcs_cmd_type c);
    has_addr = c inside {sfcs_pkg::sfcs_cmd_read,
      sfcs_pkg::sfcs_cmd_program, sfcs_pkg::sfcs_cmd_sect_erase};
  endfunction : has_addr

  function automatic logic writes(sfcs_pkg::sfcs_cmd_type c);
    writes = c inside {sfcs_pkg::sfcs_cmd_chip_erase,
      sfcs_pkg::sfcs_cmd_program, sfcs_pkg::sfcs_cmd_sect_erase};
  endfunction : writes

  function automatic logic [9:0] frame_len(sfcs_pkg::sfcs_step_type s,
      sfcs_pkg::sfcs_cmd_type c, logic [8:0] n);
    frame_len = 10'h001;
    if (s == sfcs_pkg::sfcs_st_wel || s == sfcs_pkg::sfcs_st_poll) begin
      frame_len = `SFCS_RDSR_LEN;
    end else if (s == sfcs_pkg::sfcs_st_main) begin
      case (c)
        sfcs_pkg::sfcs_cmd_rdid: frame_len = `SFCS_RDID_LEN;
        sfcs_pkg::sfcs_cmd_rdsr: frame_len = `SFCS_RDSR_LEN;
        sfcs_pkg::sfcs_cmd_sect_erase: frame_len = `SFCS_ADDR_LEN;
        sfcs_pkg::sfcs_cmd_read,
        sfcs_pkg::sfcs_cmd_program: begin
          frame_len = `SFCS_ADDR_LEN + {1'b0, n};
        end
        default: frame_len = 10'h001;
      endcase
    end
  endfunction : frame_len

  // Byte on the wire for the current frame position
  always_comb begin
    tx_now = 8'h00;
    case (q.step)
      sfcs_pkg::sfcs_st_wren: tx_now = `SFCS_OP_WREN;
      sfcs_pkg::sfcs_st_main: begin
        if (q.idx == 10'h000) begin
          tx_now = opcode(q.op);
        end else if (q.idx < `SFCS_ADDR_LEN && has_addr(q.op)) begin
          case (q.idx[1:0])
            2'b01: tx_now = q.addr[23:16];
            2'b10: tx_now = q.addr[15:8];
            default: tx_now = q.addr[7:0];
          endcase
        end else if (q.op == sfcs_pkg::sfcs_cmd_program) begin
          tx_now = wr_data;
        end
      end
      default: begin
        if (q.idx == 10'h000) begin
          tx_now = `SFCS_OP_RDSR;
        end
      end
    endcase
  end

  assign need_wr = q.phase == sfcs_pkg::sfcs_ph_issue &&
    q.step == sfcs_pkg::sfcs_st_main &&
    q.op == sfcs_pkg::sfcs_cmd_program && q.idx >= `SFCS_ADDR_LEN;

  // Block count of a file request
  assign al_blk = {1'b0, alloc_bytes[24:`SFCS_BLK_LSB]} +
    {13'h0000, |alloc_bytes[`SFCS_BLK_LSB-1:0]};
  assign al_base = (al_blk == 14'h0000) ? 14'h0001 : al_blk;
  assign al_dbl = {al_base, 1'b0};
  assign al_need = !alloc_safe ? {1'b0, al_base} :
    (al_dbl < `SFCS_SAFE_MIN_BLK) ? `SFCS_SAFE_MIN_BLK : al_dbl;
  assign al_fit = {2'b00, q.next_blk} + al_need <= {2'b00, q.fs_blks};
  assign al_pass = al_fit && q.files < `SFCS_MAX_FILES &&
    alloc_bytes <= `SFCS_MAX_FILE;

  always_comb begin
    logic fin;
    sfcs_pkg::sfcs_step_type nxt;
    fin = 1'b0;
    nxt = q.step;
    d = q;
    d.ack_s1 = lnk.ack_tgl;
    d.ack_s2 = q.ack_s1;
    d.rd_valid = 1'b0;
    d.done = 1'b0;
    d.err = 1'b0;
    d.al_done = 1'b0;
    d.ap_hit = ap_addr[31:12] == `SFCS_AP_PAGE;
    case (q.phase)
      sfcs_pkg::sfcs_ph_idle: begin
        if (cmd_valid) begin
          if (cmd_op == sfcs_pkg::sfcs_cmd_program &&
              (cmd_len == 9'h000 || cmd_len > `SFCS_PP_MAX)) begin
            d.err = 1'b1;
          end else begin
            d.op = cmd_op;
            d.len = cmd_len;
            d.addr = cmd_addr;
            if (cmd_op == sfcs_pkg::sfcs_cmd_sect_erase) begin
              d.addr = {cmd_addr[23:12], 12'h000};
            end
            d.step = (writes(cmd_op) || cmd_op == sfcs_pkg::sfcs_cmd_wren) ?
              sfcs_pkg::sfcs_st_wren : sfcs_pkg::sfcs_st_main;
            d.nbytes = frame_len(d.step, cmd_op, cmd_len);
            d.idx = 10'h000;
            d.phase = sfcs_pkg::sfcs_ph_issue;
          end
        end
      end
      sfcs_pkg::sfcs_ph_issue: begin
        if (!need_wr || wr_valid) begin
          d.txb = tx_now;
          d.req = ~q.req;
          d.cs_n = 1'b0;
          d.phase = sfcs_pkg::sfcs_ph_wait;
        end
      end
      sfcs_pkg::sfcs_ph_wait: begin
        if (q.ack_s2 == q.req) begin
          d.idx = q.idx + 10'h001;
          if (q.step != sfcs_pkg::sfcs_st_main) begin
            if (q.idx == 10'h001) begin
              d.stat = lnk.rx_byte;
            end
          end else if (q.op == sfcs_pkg::sfcs_cmd_rdid && q.idx != 10'h000) begin
            d.id = {q.id[15:0], lnk.rx_byte};
            d.rd = lnk.rx_byte;
            d.rd_valid = 1'b1;
          end else if (q.op == sfcs_pkg::sfcs_cmd_rdsr && q.idx != 10'h000) begin
            d.stat = lnk.rx_byte;
            d.rd = lnk.rx_byte;
            d.rd_valid = 1'b1;
          end else if (q.op == sfcs_pkg::sfcs_cmd_read &&
              q.idx >= `SFCS_ADDR_LEN) begin
            d.rd = lnk.rx_byte;
            d.rd_valid = 1'b1;
          end
          if (q.idx + 10'h001 == q.nbytes) begin
            d.cs_n = 1'b1;
            d.gap = 3'(`SFCS_GAP_CYC);
            d.phase = sfcs_pkg::sfcs_ph_gap;
          end else begin
            d.phase = sfcs_pkg::sfcs_ph_issue;
          end
        end
      end
      default: begin
        if (q.gap != 3'h0) begin
          d.gap = q.gap - 3'h1;
        end else begin
          case (q.step)
            sfcs_pkg::sfcs_st_wren: nxt = sfcs_pkg::sfcs_st_wel;
            sfcs_pkg::sfcs_st_wel: begin
              if (q.stat[`SFCS_ST_WEL]) begin
                fin = q.op == sfcs_pkg::sfcs_cmd_wren;
                nxt = sfcs_pkg::sfcs_st_main;
              end
            end
            sfcs_pkg::sfcs_st_main: begin
              fin = !writes(q.op);
              nxt = sfcs_pkg::sfcs_st_poll;
            end
            default: fin = !q.stat[`SFCS_ST_BUSY];
          endcase
          d.idx = 10'h000;
          if (fin) begin
            d.done = 1'b1;
            d.phase = sfcs_pkg::sfcs_ph_idle;
          end else begin
            d.step = nxt;
            d.nbytes = frame_len(nxt, q.op, q.len);
            d.phase = sfcs_pkg::sfcs_ph_issue;
          end
        end
      end
    endcase
    // Format wins over a file request in the same cycle
    if (fmt_valid) begin
      d.fs_blks = fmt_blocks;
      d.files = 8'h00;
      d.next_blk = 13'h0000;
    end else if (alloc_valid) begin
      d.al_done = 1'b1;
      d.al_ok = al_pass;
      d.al_addr = 24'h000000;
      if (al_pass) begin
        d.al_addr = {q.next_blk[11:0], 12'h000};
        d.files = q.files + 8'h01;
        d.next_blk = q.next_blk + al_need[12:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= '0;
      q.cs_n <= `SFCS_CS_RST;
    end else begin
      q <= d;
    end
  end

  assign lnk.req_tgl = q.req;
  assign lnk.tx_byte = q.txb;

  sfcs_spi_engine sfcs_spi_engine_inst (
    .link_clk(link_clk),
    .sys_rst(sys_rst),
    .lnk(lnk),
    .flash_spi_miso(flash_spi_miso),
    .flash_spi_sck(flash_spi_sck),
    .flash_spi_mosi(flash_spi_mosi)
  );

  assign cmd_ready = q.phase == sfcs_pkg::sfcs_ph_idle;
  assign wr_ready = need_wr;
  assign rd_data = q.rd;
  assign rd_valid = q.rd_valid;
  assign cmd_done = q.done;
  assign cmd_err = q.err;
  assign flash_id = q.id;
  assign flash_status = q.stat;
  assign alloc_done = q.al_done;
  assign alloc_ok = q.al_ok;
  assign alloc_addr = q.al_addr;
  assign ap_hit = q.ap_hit;
  assign flash_spi_cs_n = q.cs_n;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_rdid;
    (q.phase == sfcs_pkg::sfcs_ph_issue && q.idx == 10'h000 &&
     q.step == sfcs_pkg::sfcs_st_main && q.op == sfcs_pkg::sfcs_cmd_rdid)
    |-> tx_now == `SFCS_OP_RDID && q.nbytes == 10'h004;
  endproperty
  a_rdid: assert property (p_rdid) else $error("bad id frame");
  property p_rdsr;
    (q.phase == sfcs_pkg::sfcs_ph_issue && q.idx == 10'h000 &&
     q.step inside {sfcs_pkg::sfcs_st_wel, sfcs_pkg::sfcs_st_poll})
    |-> tx_now == `SFCS_OP_RDSR && q.nbytes == 10'h002;
  endproperty
  a_rdsr: assert property (p_rdsr) else $error("bad status frame");
  property p_wel;
    (q.step == sfcs_pkg::sfcs_st_wel && d.step == sfcs_pkg::sfcs_st_main)
    |-> q.stat[1];
  endproperty
  a_wel: assert property (p_wel) else $error("left poll early");
  property p_wren_first;
    (q.phase == sfcs_pkg::sfcs_ph_idle && d.phase == sfcs_pkg::sfcs_ph_issue)
    |-> (d.step == sfcs_pkg::sfcs_st_wren) == writes(cmd_op) ||
        cmd_op == sfcs_pkg::sfcs_cmd_wren;
  endproperty
  a_wren_first: assert property (p_wren_first) else $error("no wren");
  property p_busy;
    (q.step == sfcs_pkg::sfcs_st_poll && q.phase == sfcs_pkg::sfcs_ph_gap &&
     d.phase == sfcs_pkg::sfcs_ph_idle) |-> !q.stat[0] ##1 cmd_done;
  endproperty
  a_busy: assert property (p_busy) else $error("done while busy");
  property p_addr;
    (q.phase == sfcs_pkg::sfcs_ph_issue && q.idx == 10'h001 &&
     q.step == sfcs_pkg::sfcs_st_main && has_addr(q.op))
    |-> tx_now == q.addr[23:16] ##1 !flash_spi_cs_n;
  endproperty
  a_addr: assert property (p_addr) else $error("bad address byte");
  property p_pp_len;
    (q.step == sfcs_pkg::sfcs_st_main && q.phase != sfcs_pkg::sfcs_ph_idle &&
     q.op == sfcs_pkg::sfcs_cmd_program)
    |-> q.len != 9'h000 && q.len <= `SFCS_PP_MAX;
  endproperty
  a_pp_len: assert property (p_pp_len) else $error("bad page count");
  property p_sect;
    (q.phase != sfcs_pkg::sfcs_ph_idle &&
     q.op == sfcs_pkg::sfcs_cmd_sect_erase) |-> q.addr[11:0] == 12'h000;
  endproperty
  a_sect: assert property (p_sect) else $error("sector misaligned");
  property p_cs;
    (q.phase == sfcs_pkg::sfcs_ph_wait) ##1
    (q.phase == sfcs_pkg::sfcs_ph_issue) |-> !flash_spi_cs_n;
  endproperty
  a_cs: assert property (p_cs) else $error("select dropped");
  logic al_addr_zero;
  assign al_addr_zero = !q.al_ok || q.al_addr == 24'h000000;
  // First file of an empty region always lands at flash address zero
  property p_region;
    (alloc_valid && !fmt_valid && q.files == 8'h00) |=> al_addr_zero;
  endproperty
  a_region: assert property (p_region) else $error("not at zero");
  property p_blk;
    (alloc_valid && !fmt_valid && !alloc_safe) ##1 (q.al_done && q.al_ok)
    |-> q.next_blk > $past(q.next_blk);
  endproperty
  a_blk: assert property (p_blk) else $error("no block taken");
  property p_safe;
    (alloc_valid && !fmt_valid && alloc_safe) ##1 (q.al_done && q.al_ok)
    |-> q.next_blk >= $past(q.next_blk) + 13'h0002;
  endproperty
  a_safe: assert property (p_safe) else $error("safe too small");
  property p_files;
    (q.al_done && q.al_ok) |-> $past(q.files) < `SFCS_MAX_FILES;
  endproperty
  a_files: assert property (p_files) else $error("too many files");
  property p_size;
    (alloc_valid && !fmt_valid && alloc_bytes > `SFCS_MAX_FILE)
    |=> q.al_done && !q.al_ok;
  endproperty
  a_size: assert property (p_size) else $error("huge file taken");
  property p_ap;
    (ap_addr == 32'h4402_0fff) |=> ap_hit;
  endproperty
  a_ap: assert property (p_ap) else $error("aperture miss");
  c_id: cover property (q.op == sfcs_pkg::sfcs_cmd_rdid && cmd_done);
  c_poll: cover property (q.step == sfcs_pkg::sfcs_st_poll &&
    q.phase == sfcs_pkg::sfcs_ph_gap && d.step == sfcs_pkg::sfcs_st_poll &&
    d.phase == sfcs_pkg::sfcs_ph_issue);
  c_refuse: cover property (q.al_done && !q.al_ok);
endmodule : sfcs_top

// ### test/sfcs_flash_model.sv
// Behavioural serial flash answering the sequencer's commands
`timescale 1ns/100ps
`include "sfcs_cfg.svh"
module sfcs_flash_model #(
  // Identity value is arbitrary
  parameter logic [23:0] ID = 24'h5a3c81
) (
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso
);
  logic [7:0] mem [0:255];
  logic [7:0] sh, op, ob;
  logic [23:0] a, ea;
  logic q, wel, wel_pend;
  int nb, nbit, busy, bad_wr;
  initial begin
    {q, wel, wel_pend, sh, op, ob, a, ea} = '0;
    {nb, nbit, busy, bad_wr} = '0;
    foreach (mem[i]) mem[i] = 8'hff;
  end
  // Released line shows the inverse, never a stale copy
  assign miso = cs_n ? ~q : q;
  function automatic logic [7:0] resp();
    case (op)
      `SFCS_OP_RDID: return 8'(ID >> (8 * (3 - nb)));
      `SFCS_OP_RDSR: return {6'h00, wel, busy != 0};
      `SFCS_OP_READ: return nb > 3 ? mem[a[7:0]] : 8'h00;
      default: return 8'h00;
    endcase
  endfunction : resp
  always @(negedge cs_n) begin
    nb = 0;
    nbit = 0;
  end
  always @(posedge sck) if (!cs_n) begin
    sh = {sh[6:0], mosi};
    nbit++;
    if (nbit % 8 == 0) begin
      if (nb == 0) op = sh;
      else if (nb < 4) a = {a[15:0], sh};
      else if (op == `SFCS_OP_PP) begin
        mem[a[7:0]] = sh;
        a++;
      end
      nb++;
    end
  end
  // Mode 0: next bit goes out on the falling edge
  always @(negedge sck) if (!cs_n) begin
    if (nbit % 8 == 0) begin
      ob = resp();
      if (op == `SFCS_OP_READ && nb > 3) a++;
    end
    q = ob[7];
    ob = {ob[6:0], 1'b0};
  end
  always @(posedge cs_n) begin
    if (op == `SFCS_OP_WREN) wel_pend = 1'b1;
    if (op == `SFCS_OP_RDSR) begin
      if (busy > 0) busy--;
      // Latch shows only on the second status read
      if (wel_pend) wel = 1'b1;
      wel_pend = 1'b0;
    end
    if (op inside {`SFCS_OP_CE, `SFCS_OP_SE, `SFCS_OP_PP}) begin
      if (!wel || busy != 0) bad_wr++;
      if (op != `SFCS_OP_PP) begin
        ea = a;
        foreach (mem[i]) mem[i] = 8'hff;
      end
      wel = 1'b0;
      busy = 2;
    end
  end
endmodule : sfcs_flash_model

// ### test/sfcs_top_bench.sv
// Self-checking bench of the flash sequencer with a flash model
`timescale 1ns/100ps
module sfcs_top_bench;
  // Identity value is arbitrary
  localparam logic [23:0] FID = 24'h5a3c81;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  sfcs_pkg::sfcs_cmd_type cmd_op = sfcs_pkg::sfcs_cmd_rdid;
  logic [23:0] cmd_addr = 24'h000000;
  logic [8:0] cmd_len = 9'h000;
  logic [7:0] wr_data = 8'h00;
  logic wr_valid = 1'b0;
  logic fmt_valid = 1'b0;
  logic [12:0] fmt_blocks = 13'h0000;
  logic alloc_valid = 1'b0;
  logic [24:0] alloc_bytes = 25'h0000000;
  logic alloc_safe = 1'b0;
  logic [31:0] ap_addr = 32'h00000000;
  logic cmd_ready, wr_ready, rd_valid, cmd_done, cmd_err, ap_hit;
  logic alloc_done, alloc_ok, flash_spi_miso;
  logic flash_spi_cs_n, flash_spi_sck, flash_spi_mosi;
  logic [7:0] rd_data, flash_status;
  logic [23:0] flash_id, alloc_addr;
  logic [7:0] rq[$], wq[$], img [0:255];
  logic [31:0] apv [0:4] = '{32'h4401ffff, 32'h44020000, 32'h44020fff,
    32'h44021000, 32'h0};
  logic [24:0] aq[$];
  logic [1:0] st;
  int n_fail = 0, comparisons = 0, cyc = 0;
  sfcs_top sfcs_top_inst (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .link_clk(link_clk),
    .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready),
    .cmd_op(cmd_op),
    .cmd_addr(cmd_addr),
    .cmd_len(cmd_len),
    .wr_data(wr_data),
    .wr_valid(wr_valid),
    .wr_ready(wr_ready),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .cmd_done(cmd_done),
    .cmd_err(cmd_err),
    .flash_id(flash_id),
    .flash_status(flash_status),
    .fmt_valid(fmt_valid),
    .fmt_blocks(fmt_blocks),
    .alloc_valid(alloc_valid),
    .alloc_bytes(alloc_bytes),
    .alloc_safe(alloc_safe),
    .alloc_done(alloc_done),
    .alloc_ok(alloc_ok),
    .alloc_addr(alloc_addr),
    .ap_addr(ap_addr),
    .ap_hit(ap_hit),
    .flash_spi_cs_n(flash_spi_cs_n),
    .flash_spi_sck(flash_spi_sck),
    .flash_spi_mosi(flash_spi_mosi),
    .flash_spi_miso(flash_spi_miso)
  );
  sfcs_flash_model #(.ID(FID)) sfcs_flash_model_inst (.cs_n(flash_spi_cs_n),
    .sck(flash_spi_sck), .mosi(flash_spi_mosi), .miso(flash_spi_miso));
  initial forever #10 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #32 link_clk = ~link_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic cmd(input sfcs_pkg::sfcs_cmd_type op,
      input logic [23:0] a, input logic [8:0] n);
    int k;
    @(posedge sys_clk);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_len <= n;
    cmd_valid <= 1'b1;
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (cmd_done !== 1'b1 && cmd_err !== 1'b1 && k < 40000);
    st = {cmd_err, cmd_done};
  endtask : cmd
  // Poll frames raise no rd_valid; the last poll must show idle
  task automatic wop(input sfcs_pkg::sfcs_cmd_type op,
      input logic [23:0] a, input logic [8:0] n);
    cmd(op, a, n);
    check(st, 2'b01);
    check(flash_status, 8'h00);
  endtask : wop
  task automatic alloc(input logic [24:0] b, input logic s,
      input logic ok, input logic [23:0] a);
    alloc_valid <= 1'b1;
    alloc_bytes <= b;
    alloc_safe <= s;
    aq.push_back({ok, a});
    @(posedge sys_clk);
  endtask : alloc
  task automatic fmt(input logic [12:0] n);
    alloc_valid <= 1'b0;
    fmt_blocks <= n;
    fmt_valid <= 1'b1;
    @(posedge sys_clk);
    fmt_valid <= 1'b0;
    @(posedge sys_clk);
  endtask : fmt
  always @(posedge sys_clk) begin
    if (wr_valid && wr_ready === 1'b1) void'(wq.pop_front());
    wr_valid <= wq.size() != 0;
    if (wq.size() != 0) wr_data <= wq[0];
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (rd_valid === 1'b1) begin
      if (rq.size() == 0) check(32'hffffffff, rd_data);
      else check(rd_data, rq.pop_front());
    end
    if (alloc_done === 1'b1) begin
      if (aq.size() == 0) check(32'hffffffff, alloc_addr);
      else check({alloc_ok, alloc_addr}, aq.pop_front());
    end
    if (cyc == 95000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    logic [7:0] n;
    logic [23:0] a;
    void'($urandom(50929));
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (24) @(posedge sys_clk);
    for (int i = 2; i >= 0; i--) rq.push_back(8'(FID >> (8 * i)));
    cmd(sfcs_pkg::sfcs_cmd_rdid, 24'h0, 9'h0);
    check(flash_id, FID);
    rq.push_back(8'h00);
    cmd(sfcs_pkg::sfcs_cmd_rdsr, 24'h0, 9'h0);
    check(st, 2'b01);
    cmd(sfcs_pkg::sfcs_cmd_program, 24'h0, 9'h000);
    check(st, 2'b10);
    cmd(sfcs_pkg::sfcs_cmd_program, 24'h0, 9'h100);
    check(st, 2'b10);
    wop(sfcs_pkg::sfcs_cmd_chip_erase, 24'h0, 9'h0);
    n = 8'($urandom_range(1, 8));
    a = {16'h0040, 8'($urandom_range(0, 240))};
    for (int i = 0; i < 255; i++) begin
      img[i] = 8'($urandom);
      if (i < n) wq.push_back(img[i]);
    end
    wop(sfcs_pkg::sfcs_cmd_program, a, {1'b0, n});
    for (int i = 0; i < n; i++) rq.push_back(img[i]);
    cmd(sfcs_pkg::sfcs_cmd_read, a, {1'b0, n});
    check(st, 2'b01);
    // Longest legal page
    for (int i = 0; i < 255; i++) wq.push_back(img[i]);
    wop(sfcs_pkg::sfcs_cmd_program, 24'h0, 9'h0ff);
    check(wq.size(), 0);
    a = 24'($urandom);
    wop(sfcs_pkg::sfcs_cmd_sect_erase, a, 9'h0);
    check(sfcs_flash_model_inst.ea, a & 24'hfff000);
    cmd(sfcs_pkg::sfcs_cmd_wren, 24'h0, 9'h0);
    check(flash_status, 8'h02);
    check(sfcs_flash_model_inst.bad_wr, 0);
    check(rq.size(), 0);
    fmt(13'h0008);
    alloc(25'h0000001, 1'b0, 1'b1, 24'h000000);
    alloc(25'h0000064, 1'b1, 1'b1, 24'h001000);
    alloc(25'h0001001, 1'b0, 1'b1, 24'h003000);
    alloc(25'h0003001, 1'b0, 1'b0, 24'h000000);
    alloc(25'h0000001, 1'b1, 1'b1, 24'h005000);
    fmt(13'h1000);
    alloc(25'h1000001, 1'b0, 1'b0, 24'h000000);
    alloc(25'h1000000, 1'b0, 1'b1, 24'h000000);
    fmt(13'h1000);
    for (int i = 0; i < 128; i++)
      alloc(25'($urandom_range(1, 4096)), 1'b0, 1'b1, 24'(i) << 12);
    alloc(25'h0000001, 1'b0, 1'b0, 24'h000000);
    alloc_valid <= 1'b0;
    apv[4] = {20'h44020, 12'($urandom)};
    foreach (apv[i]) begin
      ap_addr <= apv[i];
      repeat (2) @(posedge sys_clk);
      check(ap_hit, apv[i][31:12] == 20'h44020);
    end
    check(aq.size(), 0);
    test_done();
  end
endmodule : sfcs_top_bench
